// *** rpb_defs.vh ***
`ifndef RPB_DEFS_VH
`define RPB_DEFS_VH
// ****************************************
// bus cycle encodings
// ****************************************
`define RPB_SIZ_BYTE      2'h1
`define RPB_SIZ_WORD      2'h2
`define RPB_SIZ_LONG      2'h0
// ****************************************
// fixed read values of absent port bits
// ****************************************
`define RPB_ABSENT_IN_VAL 1'h1
`define RPB_RMW_BIT_VAL   1'h0
// ****************************************
// boot vector address and reset values
// ****************************************
`define RPB_BOOT_ADDR     24'h000000
`define RPB_DATA_RST      16'h0000
`define RPB_LVL_RST       3'h0
// ****************************************
// interrupt levels usable without low pins
// ****************************************
`define RPB_LVL_SEVEN     3'h7
`define RPB_LVL_SIX       3'h6
// ****************************************
// timing: data pin synchroniser depth
// ****************************************
`define RPB_SYNC_DEPTH    3
`endif

// *** rpb_pin_sync.v ***
`timescale 1ns/1ps
`include "rpb_defs.vh"
// ****************************************
// three-stage pin synchroniser
// ****************************************
module rpb_pin_sync #(
  parameter WIDTH = 1
) (
  // clock and reset
  input  wire             clock,
  input  wire             arst_n,
  // raw pin and settled value
  input  wire [WIDTH-1:0] pin,
  output reg  [WIDTH-1:0] level
);
  reg [WIDTH-1:0] stage1;  // metastable stage, read only by stage2
  reg [WIDTH-1:0] stage2;  // second stage
  reg [WIDTH-1:0] stage3;  // third stage
  integer i;

  // shift chain; a bit changes only once stages two and three agree
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      stage1 <= {WIDTH{1'b0}};
      stage2 <= {WIDTH{1'b0}};
      stage3 <= {WIDTH{1'b0}};
      level  <= {WIDTH{1'b0}};
    end else begin
      stage1 <= pin;
      stage2 <= stage1;
      stage3 <= stage2;
      for (i = 0; i < WIDTH; i = i + 1) begin
        if (stage2[i] == stage3[i]) begin
          level[i] <= stage3[i];
        end
      end
    end
  end
endmodule

// *** rpb_irq_prio.v ***
`timescale 1ns/1ps
`include "rpb_defs.vh"
// ****************************************
// interrupt level and arbitration selection
// ****************************************
module rpb_irq_prio (
  // external requests, active low, already synchronised
  input  wire       irq7_n,
  input  wire       irq6_n,
  // internal module request
  input  wire [2:0] int_level,
  input  wire [3:0] int_arb,
  // external arbitration priority
  input  wire [3:0] ext_arb,
  // result
  output reg  [2:0] win_level,
  output reg        win_external
);
  reg [2:0] ext_level;  // level of highest external request

  // each pin signals its own number; internal wins on a level tie only
  // when its arbitration field is higher
  always @* begin
    ext_level = `RPB_LVL_RST;
    if (!irq6_n) begin
      ext_level = `RPB_LVL_SIX;
    end
    if (!irq7_n) begin
      ext_level = `RPB_LVL_SEVEN;
    end
    win_level    = ext_level;
    win_external = (ext_level != `RPB_LVL_RST);
    if (int_level > ext_level) begin
      win_level    = int_level;
      win_external = 1'b0;
    end else if (int_level == ext_level && int_level != `RPB_LVL_RST) begin
      win_external = (ext_arb >= int_arb);
    end
  end
endmodule

// *** rpb_core.v ***
`timescale 1ns/1ps
`include "rpb_defs.vh"
module rpb_core #(
  parameter RMW_BIT_VAL = `RPB_RMW_BIT_VAL  // fixed read of absent rmw bit
) (
  // clock and reset
  input  wire        clock,
  input  wire        arst_n,
  // cycle request from the processor side
  input  wire        req_valid,
  input  wire        req_write,
  input  wire [23:0] req_addr,
  input  wire [1:0]  req_size,
  input  wire [15:0] req_wdata,
  input  wire        req_rmw,
  input  wire        req_iack,
  input  wire        req_byte_port,
  // internal chip-select acknowledges, incl. hidden upper selects
  input  wire        cs_word_ack,
  input  wire        cs_autovector,
  // bus pins
  input  wire        word_size_ack_n,
  input  wire        autovector_request_n,
  input  wire [15:0] data_in,
  output reg  [15:0] data_out,
  output reg  [15:0] data_oe_n,
  output reg  [23:0] addr_out,
  output reg         strobe_n,
  output reg         rw,
  output reg         rmw_cycle_flag_n,
  // interrupt pins and internal interrupt source
  input  wire        irq7_n,
  input  wire        irq6_n,
  input  wire [2:0]  int_level,
  input  wire [3:0]  int_arb,
  input  wire [3:0]  arb_priority_field,
  // port configuration for absent-pin bits
  input  wire        byte_ack_port_io,
  input  wire        byte_ack_port_dir,
  input  wire        autovector_port_dir,
  input  wire [5:1]  int_request_port_dir,
  input  wire [6:4]  upper_port_wr,
  // results
  output reg         done,
  output reg  [15:0] rdata,
  output reg         vector_internal,
  output reg  [2:0]  irq_level,
  output reg         irq_external,
  output reg         byte_ack_port_bit,
  output reg         autovector_port_bit,
  output reg         rmw_port_bit,
  output reg  [5:1]  int_request_port_bits,
  output reg  [6:4]  upper_port_bits,
  output reg         halt_unavailable
);
  // ****************************************
  // state encoding
  // ****************************************
  localparam ST_IDLE = 2'h0;  // waiting for a request
  localparam ST_WAIT = 2'h1;  // strobe out, waiting for acknowledge
  localparam ST_REL  = 2'h2;  // strobe removed, waiting for ack release

  reg  [1:0]  state;           // cycle sequencer state
  reg  [1:0]  next_state;      // next sequencer state
  reg         cur_write;       // latched direction
  reg         cur_odd;         // latched address bit 0
  reg         cur_byte;        // latched byte size
  reg         cur_bport;       // latched byte-port word read
  reg         cur_iack;        // latched interrupt acknowledge
  reg         cur_rmw;         // latched indivisible flag
  wire [15:0] data_s;          // synchronised data pins
  wire        ack_s_n;         // synchronised word acknowledge
  wire        autovector_request_s_n;        // synchronised autovector pin
  wire [2:0]  win_level;       // arbitration winner level
  wire        win_ext;         // arbitration winner is external
  wire        irq7_s_n;        // synchronised level-seven request
  wire        irq6_s_n;        // synchronised level-six request
  wire        ack_act;         // word acknowledge, active high after sync
  wire        autovector_request_act;        // autovector pin, active high after sync
  wire        irq7_act;        // level-seven request, active high after sync
  wire        irq6_act;        // level-six request, active high after sync
  wire        u_spare;         // padding bit of the sync bundle, unused

  // ****************************************
  // pin synchronisers
  // ****************************************
  // active-low pins are inverted ahead of the chain so that its all-zero
  // reset state reads as idle; otherwise the first cycles after reset
  // would see a false acknowledge and a false level-seven request
  // data and acknowledge share one chain, so the data that came with the
  // acknowledge reaches the logic in the same cycle as the acknowledge
  rpb_pin_sync #(.WIDTH(21)) u_sync (
    .clock  (clock),
    .arst_n (arst_n),
    .pin    ({data_in, ~word_size_ack_n, ~autovector_request_n,
              ~irq7_n, ~irq6_n, 1'b0}),
    .level  ({data_s, ack_act, autovector_request_act, irq7_act, irq6_act, u_spare})
  );

  // back to active-low for the logic below
  assign ack_s_n  = !ack_act;
  assign autovector_request_s_n = !autovector_request_act;
  assign irq7_s_n = !irq7_act;
  assign irq6_s_n = !irq6_act;

  // ****************************************
  // interrupt priority
  // ****************************************
  rpb_irq_prio u_prio (
    .irq7_n       (irq7_s_n),
    .irq6_n       (irq6_s_n),
    .int_level    (int_level),
    .int_arb      (int_arb),
    .ext_arb      (arb_priority_field),
    .win_level    (win_level),
    .win_external (win_ext)
  );

  // ****************************************
  // cycle termination
  // ****************************************
  // without a byte acknowledge pin the only external answer is the word
  // acknowledge; an upper-lane byte peripheral must use it as well, and
  // then only even byte addresses reach that peripheral
  // the hidden upper selects have no pin but their select logic still
  // answers, so cs_word_ack and cs_autovector come in from that logic
  // limitation: a misaligned transfer is not split here; the processor
  // side must issue aligned requests only
  // trade-off: long transfers are run as one word cycle, the processor
  // side sequences the second half
  // any acknowledge, external or from chip-select logic, ends a cycle
  // as a word transfer; there is no byte acknowledge input at all
  wire any_ack = !ack_s_n || cs_word_ack;
  wire autovector_request    = cur_iack && (!autovector_request_s_n || cs_autovector);

  // lane selection: odd byte comes from the low lane; byte-port word
  // read takes all sixteen pins whatever they carry
  function [15:0] lane_pick;
    input [15:0] d;
    input        byte_sz;
    input        odd;
    begin
      if (byte_sz && odd) begin
        lane_pick = {8'h00, d[7:0]};
      end else if (byte_sz) begin
        lane_pick = {8'h00, d[15:8]};
      end else begin
        lane_pick = d;
      end
    end
  endfunction

  // ****************************************
  // sequencer next state
  // ****************************************
  // the release state keeps a held acknowledge from ending the next
  // cycle early, at a cost of one cycle per transfer, or six while the pin acknowledge passes the synchroniser
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (req_valid) begin
          next_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (any_ack || autovector_request) begin
          next_state = ST_REL;
        end
      end
      ST_REL: begin
        if (ack_s_n) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // ****************************************
  // bus cycle registers
  // ****************************************
  // address starts at zero so the first fetch after reset is the vector
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state            <= ST_IDLE;
      cur_write        <= 1'b0;
      cur_odd          <= 1'b0;
      cur_byte         <= 1'b0;
      cur_bport        <= 1'b0;
      cur_iack         <= 1'b0;
      cur_rmw          <= 1'b0;
      addr_out         <= `RPB_BOOT_ADDR;
      data_out         <= `RPB_DATA_RST;
      data_oe_n        <= 16'hffff;
      strobe_n         <= 1'b1;
      rw               <= 1'b1;
      rmw_cycle_flag_n <= 1'b1;
      done             <= 1'b0;
      rdata            <= `RPB_DATA_RST;
      vector_internal  <= 1'b0;
    end else begin
      state           <= next_state;
      done            <= 1'b0;
      vector_internal <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (req_valid) begin
            cur_write        <= req_write;
            cur_odd          <= req_addr[0];
            cur_byte         <= (req_size == `RPB_SIZ_BYTE);
            cur_bport        <= req_byte_port;
            cur_iack         <= req_iack;
            cur_rmw          <= req_rmw;
            addr_out         <= req_addr;
            data_out         <= req_wdata;
            data_oe_n        <= req_write ? 16'h0000 : 16'hffff;
            strobe_n         <= 1'b0;
            rw               <= !req_write;
            rmw_cycle_flag_n <= !req_rmw;
          end else if (!cur_rmw) begin
            rmw_cycle_flag_n <= 1'b1;
          end
        end
        ST_WAIT: begin
          // strobe and address stand until an acknowledge is seen
          if (any_ack || autovector_request) begin
            // end of cycle: release strobe and data drivers together
            strobe_n  <= 1'b1;
            data_oe_n <= 16'hffff;
            done      <= 1'b1;
            if (autovector_request) begin
              vector_internal <= 1'b1;
            end else if (!cur_write) begin
              rdata <= lane_pick(data_s, cur_byte && !cur_bport, cur_odd);
            end
          end
        end
        ST_REL: begin
          // waiting here for the pin acknowledge to go away
          // indivisible sequence keeps the flag until a plain request
          cur_rmw <= cur_rmw && req_rmw;
        end
        default: begin
          strobe_n <= 1'b1;
        end
      endcase
    end
  end

  // ****************************************
  // absent-pin port reads and status
  // ****************************************
  // these bits read back as fixed values because no pin stands behind
  // them; software that polls them sees a steady level, never noise
  // the reads are registered so that every output comes from a flop,
  // at the cost of one cycle of latency after a direction change
  // the interrupt winner is registered here too, one cycle after the
  // synchronised request pins
  // hazard: a port bit whose direction is set to output reads zero,
  // since no output latch exists behind an absent pin
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      irq_level             <= `RPB_LVL_RST;
      irq_external          <= 1'b0;
      byte_ack_port_bit     <= 1'b0;
      autovector_port_bit   <= 1'b0;
      rmw_port_bit          <= 1'b0;
      int_request_port_bits <= 5'h00;
      upper_port_bits       <= 3'h0;
      halt_unavailable      <= 1'b1;
    end else begin
      irq_level    <= win_level;
      irq_external <= win_ext;
      byte_ack_port_bit <= (byte_ack_port_io && !byte_ack_port_dir)
                           ? `RPB_ABSENT_IN_VAL : 1'b0;
      autovector_port_bit <= !autovector_port_dir
                             ? `RPB_ABSENT_IN_VAL : 1'b0;
      rmw_port_bit <= RMW_BIT_VAL;
      int_request_port_bits <= ~int_request_port_dir;
      // writes to the upper port bits are dropped: no output function
      upper_port_bits <= upper_port_wr & 3'h0;
      // no halt pin: no suspend, retry or single step, no fault output
      halt_unavailable <= 1'b1;
    end
  end
endmodule

// *** rpb_core_assertions.sv ***
`timescale 1ns/1ps
// ****************************************
// port-level checker for the bus fallbacks
// ****************************************
module rpb_core_chk #(
  parameter RMW_BIT_VAL = 1'b0  // fixed read of the absent rmw bit
) (
  // clock and reset
  input wire       clock,
  input wire       arst_n,
  // watched signals
  input wire       done,
  input wire       strobe_n,
  input wire       vector_internal,
  input wire       halt_unavailable,
  input wire [6:4] upper_port_bits,
  input wire       rmw_port_bit,
  input wire       autovector_port_dir,
  input wire       autovector_port_bit,
  input wire [5:1] int_request_port_dir,
  input wire [5:1] int_request_port_bits,
  input wire       byte_ack_port_io,
  input wire       byte_ack_port_dir,
  input wire       byte_ack_port_bit,
  input wire       irq7_n,
  input wire [2:0] irq_level
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  // halt functions never come back without the pin
  AST_HALT_GONE: assert property (halt_unavailable)
    else $error("halt reported available");
  // upper port bits never act as discrete outputs
  AST_UPPER_NO_OUT: assert property (upper_port_bits == 3'h0)
    else $error("upper port bits driven");
  AST_RMW_FIXED: assert property (rmw_port_bit == RMW_BIT_VAL)
    else $error("rmw port bit not fixed");
  AST_AUTOVECTOR_REQUEST_BIT_ONE: assert property (!autovector_port_dir [*3] |-> autovector_port_bit)
    else $error("autovector port bit input not one");
  AST_INTREQ_ONES: assert property ((int_request_port_dir == 5'h00) [*3]
    |-> int_request_port_bits == 5'h1f)
    else $error("request port bits not ones");
  AST_BYTEACK_ONE: assert property ((byte_ack_port_io && !byte_ack_port_dir) [*3]
    |-> byte_ack_port_bit)
    else $error("byte ack port bit not one");
  // a cycle only ends after a strobed bus cycle
  AST_DONE_AFTER_STROBE: assert property (done |-> $past(!strobe_n) && strobe_n)
    else $error("done without strobed cycle");
  AST_DONE_PULSE: assert property (done |=> !done)
    else $error("done longer than one cycle");
  AST_VEC_WITH_DONE: assert property (vector_internal |-> done)
    else $error("internal vector outside cycle end");
  AST_IRQ7_LEVEL: assert property (!irq7_n [*6] |-> irq_level == 3'h7)
    else $error("level seven request not seen");
  // main scenarios reached
  COV_DONE: cover property (done);
  COV_VEC: cover property (vector_internal);
  COV_L6: cover property (irq_level == 3'h6);
endmodule
bind rpb_core rpb_core_chk #(.RMW_BIT_VAL(RMW_BIT_VAL)) u_rpb_core_chk (.*);

// *** rpb_periph_model.sv ***
`timescale 1ns/1ps
// ****************************************
// external peripheral acknowledging as a word port
// ****************************************
module rpb_periph_model (
  // clock and reset
  input wire        clock,
  input wire        arst_n,
  // bus from the device
  input wire        strobe_n,
  input wire [23:0] addr_out,
  input wire [3:0]  wait_cycles,
  // answer to the device
  output reg        word_size_ack_n,
  output reg [15:0] data_in
);
  reg [3:0] cnt;  // wait states counted so far
  // ack after the wait, release once strobe rises; released data lines toggle
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cnt             <= 4'h0;
      word_size_ack_n <= 1'b1;
      data_in         <= 16'h5a5a;
    end else if (!strobe_n) begin
      if (cnt == wait_cycles) begin
        word_size_ack_n <= 1'b0;
        data_in         <= {addr_out[7:0], ~addr_out[7:0]};
      end else begin
        cnt     <= cnt + 4'h1;
        data_in <= ~data_in;
      end
    end else begin
      cnt             <= 4'h0;
      word_size_ack_n <= 1'b1;
      data_in         <= ~data_in;
    end
  end
endmodule

// *** test_reduced_pin_bus_fallbacks.sv ***
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin bad_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
// ****************************************
// bench for the reduced pin bus fallbacks
// ****************************************
module test_reduced_pin_bus_fallbacks;
  reg clock = 0, arst_n = 0, req_valid = 0, req_iack = 0, req_bp = 0, cs_av = 0;
  reg irq7_n = 1, irq6_n = 1, bio = 1, bdir = 0, avdir = 0, cs_ack = 0;
  reg [23:0] req_addr = 24'h0;
  reg [1:0] req_size = 2'h2;
  reg [2:0] int_level = 3'h0;
  reg [3:0] int_arb = 4'h0, arb = 4'h0, wt = 4'h1;
  reg [4:0] irdir = 5'h00;
  wire [15:0] data_in, rdata;
  wire [23:0] addr_out;
  wire strobe_n, ack_n, done, vec, halt, bab, avb, rmwb, irq_ext;
  wire [2:0] irq_level;
  wire [4:0] irb;
  wire [2:0] upb;
  int bad_count = 0, n_compared = 0, i, n;
  // rows: address, size, byte port, lane mask, expected data
  typedef struct {logic [23:0] a; logic [1:0] s; logic bp; logic [15:0] m, e;} row_t;
  row_t rows[4] = '{'{24'h000000, 2'h2, 1'b0, 16'hffff, 16'h00ff},
                    '{24'h000010, 2'h1, 1'b0, 16'h00ff, 16'h0010},
                    '{24'h000011, 2'h1, 1'b0, 16'h00ff, 16'h00ee},
                    '{24'h000020, 2'h2, 1'b1, 16'hffff, 16'h20df}};
  initial forever #2.5 clock = ~clock;
  rpb_core u_rpb_core (.clock(clock), .arst_n(arst_n), .req_valid(req_valid), .req_write(1'b0),
    .req_addr(req_addr), .req_size(req_size), .req_wdata(16'h0), .req_rmw(1'b0),
    .req_iack(req_iack), .req_byte_port(req_bp), .cs_word_ack(cs_ack), .cs_autovector(cs_av),
    .word_size_ack_n(ack_n), .autovector_request_n(1'b1), .data_in(data_in), .data_out(),
    .data_oe_n(), .addr_out(addr_out), .strobe_n(strobe_n), .rw(), .rmw_cycle_flag_n(),
    .irq7_n(irq7_n), .irq6_n(irq6_n), .int_level(int_level), .int_arb(int_arb),
    .arb_priority_field(arb), .byte_ack_port_io(bio), .byte_ack_port_dir(bdir),
    .autovector_port_dir(avdir), .int_request_port_dir(irdir), .upper_port_wr(3'h7),
    .done(done), .rdata(rdata), .vector_internal(vec), .irq_level(irq_level),
    .irq_external(irq_ext), .byte_ack_port_bit(bab), .autovector_port_bit(avb),
    .rmw_port_bit(rmwb), .int_request_port_bits(irb), .upper_port_bits(upb),
    .halt_unavailable(halt));
  rpb_periph_model u_rpb_periph_model (.clock(clock), .arst_n(arst_n), .strobe_n(strobe_n),
    .addr_out(addr_out), .wait_cycles(wt), .word_size_ack_n(ack_n), .data_in(data_in));
  // one read cycle; holds the request until strobe falls, samples at done
  task automatic rd(input [23:0] a, input [1:0] s, input bp, input ia);
    @(posedge clock);
    req_valid <= 1'b1; req_addr <= a; req_size <= s; req_bp <= bp; req_iack <= ia;
    n = 0;
    do begin @(negedge clock); n++; end while (strobe_n && n < 20);
    `CHK(addr_out, a)
    @(posedge clock);
    req_valid <= 1'b0;
    n = 0;
    do begin @(negedge clock); n++; end while (done !== 1'b1 && n < 40);
    `CHK(done, 1'b1)
  endtask
  task results;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // watchdog sized well past the roughly 135 cycles the tests need
  initial begin #50000; bad_count++; results; end
  initial begin
    repeat (12) @(posedge clock);
    `CHK(strobe_n, 1'b1)
    `CHK(halt, 1'b1)
    arst_n <= 1'b1;
    for (i = 0; i < 4; i++) begin
      rd(rows[i].a, rows[i].s, rows[i].bp, 1'b0);
      `CHK(rdata & rows[i].m, rows[i].e)
      repeat (10) @(posedge clock);
      $display("row %0d ended", i);
    end
    cs_ack <= 1'b1; // select logic of a hidden select ends the cycle
    rd(24'h000030, 2'h2, 1'b0, 1'b0);
    cs_ack <= 1'b0;
    repeat (10) @(posedge clock);
    $display("select ack ended");
    wt <= 4'h9; // slow peripheral, autovectored iack
    cs_av <= 1'b1;
    rd(24'h00fff0, 2'h1, 1'b0, 1'b1);
    `CHK(vec, 1'b1)
    cs_av <= 1'b0;
    repeat (10) @(posedge clock);
    $display("iack ended");
    `CHK({bab, avb, irb, upb, rmwb, halt}, 12'hfe1)
    irq7_n <= 1'b0;
    repeat (8) @(posedge clock);
    `CHK({irq_level, irq_ext}, 4'hf)
    irq7_n <= 1'b1; irq6_n <= 1'b0; int_level <= 3'h6; int_arb <= 4'h3; arb <= 4'h3;
    repeat (8) @(posedge clock);
    `CHK({irq_level, irq_ext}, 4'hd)
    arb <= 4'h2;
    repeat (4) @(posedge clock);
    `CHK({irq_level, irq_ext}, 4'hc)
    $display("interrupt ended");
    results;
  end
endmodule
